// ---- phy_stat_pkg.sv ----
// Package for the PHY statistics counters and coding sublayer config block.
// Assumes a 125 MHz core clock and a 5-bit management register address.
package phy_stat_pkg;

    // Management register addresses
    localparam logic [4:0] ADDR_LINK_DROP    = 5'h12;
    localparam logic [4:0] ADDR_FALSE_CARR   = 5'h13;
    localparam logic [4:0] ADDR_RX_ERR_PKT   = 5'h15;
    localparam logic [4:0] ADDR_SILICON_REV  = 5'h16;
    localparam logic [4:0] ADDR_CODING_CFG   = 5'h17;

    // Coding sublayer config field positions
    localparam int BIT_NRZI_EN      = 15;
    localparam int BIT_TIMER_LONG   = 14;
    localparam int BIT_TIMER_DIS    = 13;
    localparam int BIT_REPEATER     = 12;
    localparam int BIT_ENC_SELECT   = 11;
    localparam int BIT_TX_FORCE_OFF = 4;

    // Reset values of the config fields
    localparam logic NRZI_EN_RST      = 1'b1;
    localparam logic TIMER_LONG_RST   = 1'b0;
    localparam logic TIMER_DIS_RST    = 1'b0;
    localparam logic ENC_SELECT_RST   = 1'b0;
    localparam logic TX_FORCE_OFF_RST = 1'b0;

    // Counter constants
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_ONE  = 16'h0001;
    localparam logic [15:0] COUNT_FULL = 16'hffff;
    localparam logic [15:0] READ_ZERO  = 16'h0000;

    // Descrambler timer intervals
    localparam int CLK_PERIOD_PS   = 8000;
    localparam int TIMER_SHORT_US  = 722;
    localparam int TIMER_LONG_MS   = 2;
    localparam int TIMER_SHORT_CYC = (TIMER_SHORT_US * 1000000) / CLK_PERIOD_PS;
    localparam int TIMER_LONG_CYC  = (TIMER_LONG_MS * 1000000000) / CLK_PERIOD_PS;
    localparam int TIMER_W         = 18;
    localparam int IDLE_W          = 8;
    localparam int MIN_IDLES_DEF   = 8;
    localparam int CIM_W           = 8;

    // Receive packet tracking states
    typedef enum logic [0:0]
    {
        RX_WAIT   = 1'b0,
        RX_IN_PKT = 1'b1
    } rx_state_t;

endpackage : phy_stat_pkg

// ---- phy_stat_counters.sv ----
// Statistics counters, silicon revision word and coding sublayer config bits.
// Assumes all event inputs are synchronous to CORE_CLK and that the serial
// management frame decoder presents one-cycle read and write strobes.

module phy_stat_counters
    import phy_stat_pkg::*;
#(
    parameter logic [15:0] SILICON_REV = 16'h0001, // Arbitrary value
    parameter int          SHORT_CYC   = TIMER_SHORT_CYC,
    parameter int          LONG_CYC    = TIMER_LONG_CYC,
    parameter int          MIN_IDLES   = MIN_IDLES_DEF
)
(
    input  wire logic        CORE_CLK,        // Core clock, 125 MHz
    input  wire logic        RST,             // Synchronous reset, high
    input  wire logic        REPEATER_STRAP,  // Repeater strap level
    input  wire logic [4:0]  REG_ADDR,        // Management register address
    input  wire logic        REG_RD,          // Read strobe
    input  wire logic        REG_WR,          // Write strobe
    input  wire logic [15:0] REG_WDATA,       // Write data
    output logic      [15:0] REG_RDATA,       // Read data, next cycle
    input  wire logic        LINK_DROP,       // Link lost pulse
    input  wire logic        FALSE_CARRIER,   // False carrier pulse
    input  wire logic        CIM_CLEAR,       // Clear monitor counter
    output logic      [7:0]  CIM_EVENT_COUNT, // Monitor's own count
    input  wire logic        RX_ACTIVE,       // Receive activity level
    input  wire logic        RX_ERROR,        // Receive error level
    input  wire logic        COLLISION,       // Collision level
    input  wire logic        TX_ACTIVE,       // Transmit activity level
    input  wire logic        FULL_DUPLEX,     // Full duplex configured
    input  wire logic        IDLE_SYMBOL,     // Idle symbol received pulse
    output logic             DESCRAM_RESYNC,  // Restart idle search pulse
    output logic             CRS_OUT,         // Carrier sense
    output logic             NRZI_ENABLE,     // NRZI coding on
    output logic             EXT_ENCODER_SEL, // 1 binary, 0 MLT-3
    output logic             TX_FORCE_OFF     // 100 Mb/s outputs idle
);

    // Parameters the counters cannot serve
    if (LONG_CYC >= (1 << TIMER_W) || SHORT_CYC >= (1 << TIMER_W) || SHORT_CYC < 2 || LONG_CYC < 2)
    begin : g_bad_timer
        $error("Timer interval does not fit the timer width");
    end
    if (MIN_IDLES < 1 || MIN_IDLES >= (1 << IDLE_W))
    begin : g_bad_idle
        $error("Minimum idle count out of range");
    end

    logic [15:0]        link_drop_tally_reg;
    logic [15:0]        false_carrier_tally_reg;
    logic [15:0]        rx_error_tally_reg;
    logic [CIM_W-1:0]   cim_count_reg;
    logic               descram_timer_long_select_reg;
    logic               descram_timer_disable_reg;
    logic               repeater_reg;
    logic               nrzi_reg;
    logic               ext_encoder_select_reg;
    logic               tx_off_reg;
    logic               crs_reg;
    logic               resync_reg;
    logic [15:0]        rdata_reg;
    logic [15:0]        rdata_next;
    logic [TIMER_W-1:0] timer_reg;
    logic [TIMER_W-1:0] timer_limit;
    logic [IDLE_W-1:0]  idle_count_reg;
    logic               timer_expire;
    logic               err_seen_reg;
    logic               coll_seen_reg;
    logic               pkt_err_end;
    logic               fc_read;
    logic               cfg_write;
    rx_state_t          rx_state_reg;

    assign fc_read   = REG_RD && (REG_ADDR == ADDR_FALSE_CARR);
    assign cfg_write = REG_WR && (REG_ADDR == ADDR_CODING_CFG);

    // Link loss counter
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            link_drop_tally_reg <= COUNT_ZERO;
        else if (LINK_DROP)
            link_drop_tally_reg <= link_drop_tally_reg + COUNT_ONE;
    end

    // False carrier counter; an event in the read cycle survives the clear
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            false_carrier_tally_reg <= COUNT_ZERO;
        else if (fc_read)
            false_carrier_tally_reg <= FALSE_CARRIER ? COUNT_ONE : COUNT_ZERO;
        else if (FALSE_CARRIER && false_carrier_tally_reg != COUNT_FULL)
            false_carrier_tally_reg <= false_carrier_tally_reg + COUNT_ONE;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            cim_count_reg <= '0;
        else if (CIM_CLEAR)
            // An event in the clear cycle is kept, as on the false carrier count
            cim_count_reg <= CIM_W'(FALSE_CARRIER);
        else if (FALSE_CARRIER && cim_count_reg != {CIM_W{1'b1}})
            cim_count_reg <= cim_count_reg + 1'b1;
    end

    // Packet tracking; errors and collisions are latched per packet
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            rx_state_reg  <= RX_WAIT;
            err_seen_reg  <= 1'b0;
            coll_seen_reg <= 1'b0;
        end
        else
        begin
            case (rx_state_reg)
                RX_WAIT:
                begin
                    if (RX_ACTIVE)
                        rx_state_reg <= RX_IN_PKT;
                    err_seen_reg  <= RX_ACTIVE && RX_ERROR;
                    coll_seen_reg <= RX_ACTIVE && COLLISION;
                end
                RX_IN_PKT:
                begin
                    if (!RX_ACTIVE)
                        rx_state_reg <= RX_WAIT;
                    err_seen_reg  <= err_seen_reg || RX_ERROR;
                    coll_seen_reg <= coll_seen_reg || COLLISION;
                end
                default:
                    rx_state_reg <= RX_WAIT;
            endcase
        end
    end

    assign pkt_err_end = (rx_state_reg == RX_IN_PKT) && !RX_ACTIVE && err_seen_reg && !coll_seen_reg;

    // Receive error packet counter
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            rx_error_tally_reg <= COUNT_ZERO;
        else if (pkt_err_end)
            rx_error_tally_reg <= rx_error_tally_reg + COUNT_ONE;
    end

    // Config bits; the repeater bit takes the strap while reset is high
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            nrzi_reg                      <= NRZI_EN_RST;
            descram_timer_long_select_reg <= TIMER_LONG_RST;
            descram_timer_disable_reg     <= TIMER_DIS_RST;
            repeater_reg                  <= REPEATER_STRAP;
            ext_encoder_select_reg        <= ENC_SELECT_RST;
            tx_off_reg                    <= TX_FORCE_OFF_RST;
        end
        else if (cfg_write)
        begin
            nrzi_reg                      <= REG_WDATA[BIT_NRZI_EN];
            descram_timer_long_select_reg <= REG_WDATA[BIT_TIMER_LONG];
            descram_timer_disable_reg     <= REG_WDATA[BIT_TIMER_DIS];
            repeater_reg                  <= REG_WDATA[BIT_REPEATER];
            ext_encoder_select_reg        <= REG_WDATA[BIT_ENC_SELECT];
            tx_off_reg                    <= REG_WDATA[BIT_TX_FORCE_OFF];
        end
    end

    // Interval end; a shortened interval mid-count ends at once
    assign timer_limit  = descram_timer_long_select_reg ? TIMER_W'(LONG_CYC - 1) : TIMER_W'(SHORT_CYC - 1);
    assign timer_expire = !descram_timer_disable_reg && (timer_reg >= timer_limit);

    // Descrambler timer and idle tally
    always_ff @(posedge CORE_CLK)
    begin
        if (RST || descram_timer_disable_reg)
        begin
            timer_reg      <= '0;
            idle_count_reg <= '0;
            resync_reg     <= 1'b0;
        end
        else if (timer_expire)
        begin
            timer_reg      <= '0;
            idle_count_reg <= '0;
            resync_reg     <= (idle_count_reg < IDLE_W'(MIN_IDLES));
        end
        else
        begin
            timer_reg  <= timer_reg + 1'b1;
            resync_reg <= 1'b0;
            if (IDLE_SYMBOL && idle_count_reg != {IDLE_W{1'b1}})
                idle_count_reg <= idle_count_reg + 1'b1;
        end
    end

    // Carrier sense; full duplex node follows receive only
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            crs_reg <= 1'b0;
        else if (repeater_reg || FULL_DUPLEX)
            crs_reg <= RX_ACTIVE;
        else
            crs_reg <= RX_ACTIVE || TX_ACTIVE;
    end

    // Read data mux; unmapped addresses read zero
    always_comb
    begin
        rdata_next = READ_ZERO;
        case (REG_ADDR)
            ADDR_LINK_DROP:   rdata_next = link_drop_tally_reg;
            ADDR_FALSE_CARR:  rdata_next = false_carrier_tally_reg;
            ADDR_RX_ERR_PKT:  rdata_next = rx_error_tally_reg;
            ADDR_SILICON_REV: rdata_next = SILICON_REV;
            ADDR_CODING_CFG:
            begin
                rdata_next[BIT_NRZI_EN]      = nrzi_reg;
                rdata_next[BIT_TIMER_LONG]   = descram_timer_long_select_reg;
                rdata_next[BIT_TIMER_DIS]    = descram_timer_disable_reg;
                rdata_next[BIT_REPEATER]     = repeater_reg;
                rdata_next[BIT_ENC_SELECT]   = ext_encoder_select_reg;
                rdata_next[BIT_TX_FORCE_OFF] = tx_off_reg;
            end
            default:          rdata_next = READ_ZERO;
        endcase
    end

    // Read data holds until the next read
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            rdata_reg <= READ_ZERO;
        else if (REG_RD)
            rdata_reg <= rdata_next;
    end

    assign REG_RDATA       = rdata_reg;
    assign CIM_EVENT_COUNT = cim_count_reg;
    assign DESCRAM_RESYNC  = resync_reg;
    assign CRS_OUT         = crs_reg;
    assign NRZI_ENABLE     = nrzi_reg;
    assign EXT_ENCODER_SEL = ext_encoder_select_reg;
    assign TX_FORCE_OFF    = tx_off_reg;

    // Checks of counter and config behaviour
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    AST_DROP_INC: assert property (LINK_DROP |=> link_drop_tally_reg == $past(link_drop_tally_reg) + COUNT_ONE)
        else $error("Link loss count did not advance");
    AST_DROP_WRAP: assert property ((LINK_DROP && link_drop_tally_reg == COUNT_FULL)
        |=> link_drop_tally_reg == COUNT_ZERO)
        else $error("Link loss count did not wrap");
    AST_FC_INC: assert property ((FALSE_CARRIER && !fc_read && false_carrier_tally_reg != COUNT_FULL)
        |=> false_carrier_tally_reg == $past(false_carrier_tally_reg) + COUNT_ONE)
        else $error("False carrier count did not advance");
    AST_FC_SAT: assert property ((false_carrier_tally_reg == COUNT_FULL && !fc_read)
        |=> false_carrier_tally_reg == COUNT_FULL)
        else $error("False carrier count left saturation");
    AST_FC_CLR: assert property ((fc_read && !FALSE_CARRIER)
        |=> false_carrier_tally_reg == COUNT_ZERO && REG_RDATA == $past(false_carrier_tally_reg))
        else $error("False carrier read did not clear");
    AST_FC_RD_EVT: assert property ((fc_read && FALSE_CARRIER) |=> false_carrier_tally_reg == COUNT_ONE)
        else $error("Event in read cycle was lost");
    AST_CIM_SEP: assert property ((fc_read && !CIM_CLEAR && !FALSE_CARRIER)
        |=> cim_count_reg == $past(cim_count_reg))
        else $error("Monitor counter disturbed by read");
    AST_RXE_ONE: assert property (pkt_err_end
        |=> rx_error_tally_reg == $past(rx_error_tally_reg) + COUNT_ONE
        ##1 rx_error_tally_reg == $past(rx_error_tally_reg))
        else $error("Errored packet not counted once");
    AST_RXE_COLL: assert property ((rx_state_reg == RX_IN_PKT && !RX_ACTIVE && coll_seen_reg)
        |=> $stable(rx_error_tally_reg))
        else $error("Collided packet was counted");
    AST_RXE_WRAP: assert property ((pkt_err_end && rx_error_tally_reg == COUNT_FULL)
        |=> rx_error_tally_reg == COUNT_ZERO)
        else $error("Receive error count did not wrap");
    AST_REV_READ: assert property ((REG_RD && REG_ADDR == ADDR_SILICON_REV) |=> REG_RDATA == SILICON_REV)
        else $error("Revision code misread");
    AST_CFG_WRITE: assert property (cfg_write
        |=> NRZI_ENABLE == $past(REG_WDATA[BIT_NRZI_EN]) && TX_FORCE_OFF == $past(REG_WDATA[BIT_TX_FORCE_OFF]))
        else $error("Config write not applied");
    AST_RESYNC: assert property ((timer_expire && idle_count_reg < IDLE_W'(MIN_IDLES))
        |=> DESCRAM_RESYNC ##1 !DESCRAM_RESYNC)
        else $error("Resync not pulsed on timeout");
    AST_IDLE_OK: assert property ((timer_expire && idle_count_reg >= IDLE_W'(MIN_IDLES)) |=> !DESCRAM_RESYNC)
        else $error("Resync despite enough idles");
    AST_TIMER_OFF: assert property (descram_timer_disable_reg |=> !DESCRAM_RESYNC)
        else $error("Resync while timer disabled");
    AST_CRS_REP: assert property ((repeater_reg && !RX_ACTIVE && TX_ACTIVE) |=> !CRS_OUT)
        else $error("Repeater carrier sense from transmit");
    AST_CRS_NODE: assert property ((!repeater_reg && !FULL_DUPLEX && TX_ACTIVE) |=> CRS_OUT)
        else $error("Node carrier sense missed transmit");
    AST_CRS_RX: assert property (RX_ACTIVE |=> CRS_OUT)
        else $error("Carrier sense missed receive");

    // Reset checks start while reset is high, so they opt out of the default disable
    AST_STRAP: assert property (disable iff (1'b0) RST |=> repeater_reg == $past(REPEATER_STRAP))
        else $error("Strap not loaded at reset");
    AST_RST_CLR: assert property (disable iff (1'b0) RST
        |=> link_drop_tally_reg == COUNT_ZERO && false_carrier_tally_reg == COUNT_ZERO
            && rx_error_tally_reg == COUNT_ZERO)
        else $error("Counters not cleared by reset");

    COV_FC_READ_EVENT: cover property (fc_read && FALSE_CARRIER);
    COV_RXE_COUNT: cover property (pkt_err_end);
    COV_RESYNC: cover property (DESCRAM_RESYNC);
    COV_DROP_WRAP: cover property (LINK_DROP && link_drop_tally_reg == COUNT_FULL);
    COV_FC_SAT: cover property (FALSE_CARRIER && false_carrier_tally_reg == COUNT_FULL);

endmodule : phy_stat_counters

// ---- mgmt_model.sv ----
// Station management model on the parallel register port of the counters.
// Assumes one caller at a time; strobes change at the falling edge only.
module mgmt_model
(
    input  wire logic        CORE_CLK,  // Core clock
    output logic      [4:0]  REG_ADDR,  // Register address
    output logic             REG_RD,    // Read strobe
    output logic             REG_WR,    // Write strobe
    output logic      [15:0] REG_WDATA, // Write data
    input  wire logic [15:0] REG_RDATA  // Read data
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet bus from time zero
    initial
    begin
        REG_ADDR  = 5'h00;
        REG_RD    = 1'b0;
        REG_WR    = 1'b0;
        REG_WDATA = 16'h0000;
    end

    // Released lines flip, so a stale value never looks valid
    task automatic release_bus();
        REG_RD    = 1'b0;
        REG_WR    = 1'b0;
        REG_ADDR  = ~REG_ADDR;
        REG_WDATA = ~REG_WDATA;
    endtask : release_bus

    // Strobe held over one rising edge, data taken after it
    task automatic rd_word(input logic [4:0] a, output logic [15:0] d);
        @(negedge CORE_CLK);
        REG_ADDR = a;
        REG_RD   = 1'b1;
        @(negedge CORE_CLK);
        d = REG_RDATA;
        release_bus();
    endtask : rd_word

    // Same framing as a read
    task automatic wr_word(input logic [4:0] a, input logic [15:0] d);
        @(negedge CORE_CLK);
        REG_ADDR  = a;
        REG_WDATA = d;
        REG_WR    = 1'b1;
        @(negedge CORE_CLK);
        release_bus();
    endtask : wr_word
endmodule : mgmt_model

// ---- tb_phy_stat_counters.sv ----
// Self-checking bench for the statistics counters and coding config bits.
// Assumes the management model owns the register port; events change at falling edge.
module tb_phy_stat_counters
    import phy_stat_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] REV   = 16'h00a5; // Arbitrary value
    localparam int          SHORT = 20;
    localparam int          LONG  = 40;

    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic        strap = 1'b1;
    logic        ld, fc, cimc, rxa, rxe, col, txa, fd, idle;
    logic [4:0]  addr;
    logic        rd, wstb, resync, crs, nrzi, encs, txoff;
    logic [15:0] wdata, rdata;
    logic [7:0]  cim;
    int          mismatches = 0;
    int          tests_run  = 0;
    int          seed       = 84;
    int          cycles     = 0;

    // Short timer counts keep the run brief
    phy_stat_counters #(.SILICON_REV(REV), .SHORT_CYC(SHORT), .LONG_CYC(LONG)) u_phy_stat_counters
    (
        .CORE_CLK(clk), .RST(rst), .REPEATER_STRAP(strap), .REG_ADDR(addr), .REG_RD(rd),
        .REG_WR(wstb), .REG_WDATA(wdata), .REG_RDATA(rdata), .LINK_DROP(ld), .FALSE_CARRIER(fc),
        .CIM_CLEAR(cimc), .CIM_EVENT_COUNT(cim), .RX_ACTIVE(rxa), .RX_ERROR(rxe), .COLLISION(col),
        .TX_ACTIVE(txa), .FULL_DUPLEX(fd), .IDLE_SYMBOL(idle), .DESCRAM_RESYNC(resync),
        .CRS_OUT(crs), .NRZI_ENABLE(nrzi), .EXT_ENCODER_SEL(encs), .TX_FORCE_OFF(txoff)
    );

    mgmt_model u_mgmt_model
    (
        .CORE_CLK(clk), .REG_ADDR(addr), .REG_RD(rd), .REG_WR(wstb), .REG_WDATA(wdata), .REG_RDATA(rdata)
    );

    // 125 MHz clock
    always #4 clk = ~clk;

    // Hang guard, well above the planned run length
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] v;
        u_mgmt_model.rd_word(a, v);
        chk(v, exp);
    endtask : rdchk

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        u_mgmt_model.wr_word(a, d);
    endtask : wr

    // Expected read-back of a config word: only the six kept bits survive
    function automatic logic [15:0] cfg_exp(input logic [15:0] w);
        return w & 16'hf810;
    endfunction : cfg_exp

    // Expected carrier sense for one mode and activity mix
    function automatic logic crs_exp(input logic rep, input logic dup, input logic rx, input logic tx);
        return rx | (tx & ~rep & ~dup);
    endfunction : crs_exp

    // Pulses held high for exactly n rising edges
    task automatic events(input int n, input logic l, input logic f);
        repeat (n)
        begin
            @(negedge clk);
            ld = l;
            fc = f;
        end
        @(negedge clk);
        ld = 1'b0;
        fc = 1'b0;
    endtask : events

    task automatic packet(input int len, input logic err, input logic c);
        @(negedge clk) rxa = 1'b1;
        repeat (len) @(negedge clk) {rxe, col} = {err, c};
        @(negedge clk) {rxa, rxe, col} = 3'b000;
        @(negedge clk);
    endtask : packet

    // Cycles between two restart pulses, bounded
    task automatic gap(output int g);
        g = 0;
        while (resync !== 1'b1 && g < 200) @(negedge clk) g++;
        g = 0;
        do @(negedge clk) g++; while (resync !== 1'b1 && g < 200);
    endtask : gap

    // Settle one long interval first, then count restart pulses
    task automatic pulses(input int n, output int k);
        k = 0;
        repeat (LONG) @(negedge clk);
        repeat (n) @(negedge clk) k += (resync === 1'b1);
    endtask : pulses

    // Main sequence
    initial
    begin
        logic [15:0] w;
        int          n;
        int          k;
        int          g;
        int          rx_exp;
        {ld, fc, cimc, rxa, rxe, col, txa, fd, idle} = '0;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        rdchk(ADDR_LINK_DROP, COUNT_ZERO);
        rdchk(ADDR_FALSE_CARR, COUNT_ZERO);
        rdchk(ADDR_RX_ERR_PKT, COUNT_ZERO);
        rdchk(ADDR_SILICON_REV, REV);
        rdchk(ADDR_CODING_CFG, 16'h9000);
        rdchk(5'h1f, READ_ZERO);
        chk({13'h0, nrzi, encs, txoff}, 16'h0004);
        // Read-only place ignores writes
        wr(ADDR_SILICON_REV, 16'h5a5a);
        rdchk(ADDR_SILICON_REV, REV);
        // Random config words, only implemented bits stick
        repeat (8)
        begin
            w = 16'($random(seed));
            wr(ADDR_CODING_CFG, w);
            rdchk(ADDR_CODING_CFG, cfg_exp(w));
            chk({13'h0, nrzi, encs, txoff}, {13'h0, w[15], w[11], w[4]});
        end
        n = 1 + ({$random(seed)} % 20);
        k = 1 + ({$random(seed)} % 20);
        events(n, 1'b1, 1'b0);
        events(k, 1'b0, 1'b1);
        rdchk(ADDR_LINK_DROP, 16'(n));
        chk({8'h0, cim}, 16'(k));
        rdchk(ADDR_FALSE_CARR, 16'(k));
        rdchk(ADDR_FALSE_CARR, COUNT_ZERO);
        chk({8'h0, cim}, 16'(k));
        // Read strobe meets the first of three events, which must outlive the clear
        fork
            events(3, 1'b0, 1'b1);
            rdchk(ADDR_FALSE_CARR, COUNT_ZERO);
        join
        rdchk(ADDR_FALSE_CARR, 16'h0003);
        // Past the top: link count wraps, false carrier holds
        events(65538, 1'b1, 1'b1);
        rdchk(ADDR_LINK_DROP, 16'(n + 2));
        rdchk(ADDR_FALSE_CARR, COUNT_FULL);
        chk({8'h0, cim}, 16'h00ff);
        @(negedge clk) cimc = 1'b1;
        @(negedge clk) cimc = 1'b0;
        chk({8'h0, cim}, 16'h0000);
        // Stray error outside a packet, collided and clean errored packets
        @(negedge clk) rxe = 1'b1;
        @(negedge clk) rxe = 1'b0;
        packet(3, 1'b1, 1'b1);
        packet(1, 1'b1, 1'b0);
        rx_exp = 1;
        repeat (12)
        begin
            n = 1 + ({$random(seed)} % 5);
            w = 16'($random(seed));
            packet(n, w[0], w[1]);
            rx_exp += int'(w[0] & ~w[1]);
        end
        rdchk(ADDR_RX_ERR_PKT, 16'(rx_exp));
        // Carrier sense over every mode and activity mix
        for (int i = 0; i < 16; i++)
        begin
            wr(ADDR_CODING_CFG, {3'b100, i[3], 12'h000});
            @(negedge clk) {fd, rxa, txa} = i[2:0];
            @(negedge clk);
            chk({15'h0, crs}, {15'h0, crs_exp(i[3], i[2], i[1], i[0])});
        end
        {fd, rxa, txa} = 3'b000;
        // Descrambler timer without idles, then disabled, then fed
        wr(ADDR_CODING_CFG, 16'h8000);
        gap(g);
        chk(16'(g), 16'(SHORT));
        wr(ADDR_CODING_CFG, 16'hc000);
        gap(g);
        gap(g);
        chk(16'(g), 16'(LONG));
        wr(ADDR_CODING_CFG, 16'ha000);
        pulses(100, k);
        chk(16'(k), 16'h0000);
        idle = 1'b1;
        wr(ADDR_CODING_CFG, 16'h8000);
        pulses(100, k);
        chk(16'(k), 16'h0000);
        // Second reset with the strap low and the false carrier count nonzero
        events(2, 1'b0, 1'b1);
        strap = 1'b0;
        rst   = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rdchk(ADDR_CODING_CFG, 16'h8000);
        rdchk(ADDR_LINK_DROP, COUNT_ZERO);
        rdchk(ADDR_RX_ERR_PKT, COUNT_ZERO);
        rdchk(ADDR_FALSE_CARR, COUNT_ZERO);
        stop_test();
    end
endmodule : tb_phy_stat_counters
